// ==== src/sflf_frame_if.sv ====
// Carrier between the flag core and its serial frame engine.
// Pin levels arrive already synchronised to core_clk.
`timescale 1ns/1ns
`default_nettype none

interface sflf_frame_if;
	logic       sclk;
	logic       cs_n;
	logic       mosi;
	logic       miso;
	logic       miso_oe;
	logic       cmd_valid;
	logic       frame_done;
	logic [8:0] cmd;
	logic [7:0] resp;

	modport spi  (input sclk, cs_n, mosi, resp, output miso, miso_oe, cmd_valid, frame_done, cmd);
	modport core (output sclk, cs_n, mosi, resp, input miso, miso_oe, cmd_valid, frame_done, cmd);
endinterface

`default_nettype wire

// ==== src/sflf_pkg.sv ====
// Shared constants, types and decode helpers of the supply and LIN fault flag bank.
// Assumes a 20 MHz core clock and a 16-bit serial command frame from the host.
`default_nettype none

package sflf_pkg;

	// ==========================================================
	// Timing
	localparam longint      CLK_HZ           = 20_000_000;
	localparam longint      QUAL_US          = 100;
	localparam longint      QUAL_CYCLES      = (QUAL_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned QUAL_W           = 11;
	localparam logic [10:0] QUAL_COUNT       = 11'(QUAL_CYCLES);
	localparam longint      SHORT_RST_MS     = 100;
	localparam longint      SHORT_RST_CYCLES = (SHORT_RST_MS * CLK_HZ) / 1_000;
	localparam int unsigned SHORT_W          = 21;

	// ==========================================================
	// Frame layout and command decode
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CMD_BITS   = 5'h09;
	localparam logic [1:0] CMD_FLAG   = 2'h3;
	localparam logic [1:0] CMD_STATUS = 2'h0;
	localparam logic [4:0] ADDR_REG   = 5'h0f;
	localparam logic [4:0] ADDR_LIN1  = 5'h13;
	localparam logic [4:0] ADDR_LIN2  = 5'h14;

	// ==========================================================
	// Bit positions inside the flag bytes
	localparam int unsigned LIN_WAKE = 6;
	localparam int unsigned AUX_LOW  = 7;
	localparam int unsigned AUX_OC   = 6;
	localparam int unsigned BUS_TH   = 5;
	localparam int unsigned BUS_UV   = 4;
	localparam int unsigned BUS_OC   = 3;
	localparam int unsigned SENSE_LO = 2;
	localparam int unsigned BATT_UV  = 1;
	localparam int unsigned MAIN_OC  = 0;
	localparam int unsigned MAIN_TH  = 4;
	localparam int unsigned SHORT_RP = 2;
	localparam int unsigned BATT_FL  = 1;
	localparam int unsigned LP_OC    = 0;

	typedef enum logic [2:0] {
		GRP_NONE, GRP_LIN1_FLAG, GRP_LIN2_FLAG, GRP_LIN1_LIVE, GRP_LIN2_LIVE, GRP_REG_A, GRP_REG_B
	} sflf_grp_type;

	// Every asynchronous pin, in the order it is synchronised
	typedef struct packed {
		logic       sclk, cs_n, mosi;
		logic [6:0] lin1_cond, lin2_cond;
		logic       lin1_state, lin1_wake_en, lin2_state, lin2_wake_en;
		logic       aux_low, aux_oc, bus_thermal, bus_uv, bus_oc, sense_low, batt_uv;
		logic       main_oc, normal_mode, lp_oc, lp_vdd_on, main_thermal_off, batt_fail;
		logic       reset_pin_n;
	} sflf_pins_type;

	// Idle pin levels, so that release of reset sees no false edge
	localparam sflf_pins_type PINS_IDLE = '{cs_n: 1'b1, reset_pin_n: 1'b1, default: '0};

	// Frame bits 15..7 to flag group; anything else reads as zero
	function automatic sflf_grp_type grp_of(input logic [8:0] cmd);
		logic [1:0] kind;
		logic [4:0] addr;
		kind = cmd[8:7];
		addr = cmd[6:2];
		grp_of = GRP_NONE;
		if (cmd[1] && kind == CMD_FLAG && !cmd[0] && addr == ADDR_LIN1) grp_of = GRP_LIN1_FLAG;
		if (cmd[1] && kind == CMD_FLAG && !cmd[0] && addr == ADDR_LIN2) grp_of = GRP_LIN2_FLAG;
		if (cmd[1] && kind == CMD_STATUS && cmd[0] && addr == ADDR_LIN1) grp_of = GRP_LIN1_LIVE;
		if (cmd[1] && kind == CMD_STATUS && cmd[0] && addr == ADDR_LIN2) grp_of = GRP_LIN2_LIVE;
		if (cmd[1] && kind == CMD_FLAG && addr == ADDR_REG) grp_of = cmd[0] ? GRP_REG_B : GRP_REG_A;
	endfunction

	// Sticky flag update: set wins, a read clears only what has gone away
	function automatic logic [7:0] next_flags(input logic [7:0] q, input logic [7:0] set,
			input logic [7:0] still, input logic clr);
		next_flags = set | (q & ~({8{clr}} & ~still));
	endfunction

endpackage

`default_nettype wire

// ==== src/sflf_qual.sv ====
// Persistence filter: output rises once a condition has held for the qualification time.
// Assumes cond is already synchronised to core_clk.
`timescale 1ns/1ns
`default_nettype none

module sflf_qual (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic cond,
	output logic      hit
);
	typedef struct packed {
		logic [sflf_pkg::QUAL_W-1:0] cnt;
		logic                        hit;
	} sflf_qual_type;

	sflf_qual_type q, d;

	// ==========================================================
	// Counter restarts on any gap, so glitches never add up
	always_comb begin
		d = q;
		if (!cond) begin
			d.cnt = '0;
		end else if (q.cnt != sflf_pkg::QUAL_COUNT) begin
			d.cnt = q.cnt + 1'b1;
		end
		d.hit = cond && (d.cnt == sflf_pkg::QUAL_COUNT);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hit = q.hit;

	a_qual_not_early: assert property (
		@(posedge core_clk) disable iff (rst) $rose(hit) |-> q.cnt == sflf_pkg::QUAL_COUNT)
		else $error("qualified output rose before the full count");
	a_qual_drop: assert property (
		@(posedge core_clk) disable iff (rst) !cond |=> !hit)
		else $error("qualified output stayed high after the condition fell");

endmodule // sflf_qual

`default_nettype wire

// ==== src/sflf_spi.sv ====
// Serial frame engine: 16-bit frames, MOSI sampled and MISO changed on SCLK rise.
// Assumes synchronised pins and SCLK half periods of at least four core clocks.
`timescale 1ns/1ns
`default_nettype none

module sflf_spi (
	input  wire logic    core_clk,
	input  wire logic    rst,
	sflf_frame_if.spi    f
);
	typedef struct packed {
		logic       sclk_prev, cs_prev, miso, oe, valid, done;
		logic [4:0] cnt;
		logic [8:0] cmd;
		logic [7:0] sh;
	} sflf_spi_type;

	sflf_spi_type q, d;
	logic         rise;

	// ==========================================================
	// Command in on the first nine rises, answer out on the last eight
	always_comb begin
		d = q;
		d.valid = 1'b0;
		d.done = 1'b0;
		d.sclk_prev = f.sclk;
		d.cs_prev = f.cs_n;
		rise = f.sclk && !q.sclk_prev;
		if (f.cs_n) begin
			d.cnt = '0;
			d.miso = 1'b0;
			d.oe = 1'b0;
			d.done = !q.cs_prev && q.cnt == sflf_pkg::FRAME_BITS; // Short frames never clear
		end else begin
			d.oe = 1'b1;
			if (q.valid) begin
				d.sh = f.resp;
				d.miso = f.resp[7];
			end
			if (rise && q.cnt != sflf_pkg::FRAME_BITS) begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt < sflf_pkg::CMD_BITS) begin
					d.cmd = {q.cmd[7:0], f.mosi};
				end
				d.valid = q.cnt == sflf_pkg::CMD_BITS - 5'h1;
				if (q.cnt >= sflf_pkg::CMD_BITS) begin
					d.sh = {q.sh[6:0], 1'b0};
					d.miso = q.sh[6];
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '{cs_prev: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign f.miso       = q.miso;
	assign f.miso_oe    = q.oe;
	assign f.cmd_valid  = q.valid;
	assign f.frame_done = q.done;
	assign f.cmd        = q.cmd;

	a_frame_length: assert property (
		@(posedge core_clk) disable iff (rst) f.frame_done |-> $past(q.cnt) == sflf_pkg::FRAME_BITS)
		else $error("frame accepted with a wrong bit count");
	a_first_resp_bit: assert property (
		@(posedge core_clk) disable iff (rst)
		(f.cmd_valid && !f.cs_n) |=> (f.cs_n || q.miso == $past(f.resp[7])))
		else $error("answer bit 7 not presented after the command");

endmodule // sflf_spi

`default_nettype wire

// ==== src/sflf_top.sv ====
// Fault and status flag bank for two LIN transceivers and the supply regulators.
// Assumes every condition input is an asynchronous level from analogue or transceiver logic.
//
// How it works
// - First LIN flag byte: bit6 wake to bit0 bus clamp, bit7 zero.
// - Second LIN flag byte, same order, returned for its own flag read.
// - First LIN live byte: state bit7, wake receiver enable bit6, rest zero.
// - Second LIN live byte: state bit7, wake enable bit6, own status read.
// - Auxiliary low sets after 100 us undervoltage; clears on recovery and read.
// - Auxiliary overcurrent sets after 100 us; clears on recovery and read.
// - Bus supply thermal sets with sensor; clears on cooling and read.
// - Bus supply undervoltage sets after 100 us; clears on recovery and read.
// - Bus driver overcurrent sets after 100 us; clears on recovery and read.
// - Sense input low sets after 100 us; clears on recovery and read.
// - Battery undervoltage sets after 100 us; clears on recovery and read.
// - Run overcurrent qualifies only in normal mode; clears on recovery and read.
// - Low-power overcurrent qualifies only with regulator on (lp_vdd_on), whatever normal_mode is.
// - Main regulator thermal-off sets while off; clears on recovery and read.
// - Reset pin low shorter than 100 ms sets flag; clears after end and read.
// - Battery fail sets below threshold; clears on recovery and read.
// - Live bytes follow hardware and a status read changes nothing.
`timescale 1ns/1ns
`default_nettype none

module sflf_top #(
	parameter int unsigned SHORT_CYCLES = 32'(sflf_pkg::SHORT_RST_CYCLES)
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso,
	output logic            miso_oe,
	input  wire logic [6:0] lin1_cond,
	input  wire logic [6:0] lin2_cond,
	input  wire logic       lin1_state,
	input  wire logic       lin1_wake_en,
	input  wire logic       lin2_state,
	input  wire logic       lin2_wake_en,
	input  wire logic       aux_low,
	input  wire logic       aux_oc,
	input  wire logic       bus_thermal,
	input  wire logic       bus_uv,
	input  wire logic       bus_oc,
	input  wire logic       sense_low,
	input  wire logic       batt_uv,
	input  wire logic       main_oc,
	input  wire logic       normal_mode,
	input  wire logic       lp_oc,
	input  wire logic       lp_vdd_on,
	input  wire logic       main_thermal_off,
	input  wire logic       batt_fail,
	input  wire logic       reset_pin_n
);

	typedef struct packed {
		sflf_pkg::sflf_pins_type          s1;
		sflf_pkg::sflf_pins_type          s2;
		logic [6:0]                       lin1;
		logic [6:0]                       lin2;
		logic [7:0]                       rega;
		logic [7:0]                       regb;
		sflf_pkg::sflf_grp_type           rd_grp;
		logic [sflf_pkg::SHORT_W-1:0]     rcnt;
		logic                             rpin_prev;
	} sflf_top_state_type;

	localparam sflf_top_state_type ST_RESET = '{
		s1: sflf_pkg::PINS_IDLE,
		s2: sflf_pkg::PINS_IDLE,
		rd_grp: sflf_pkg::GRP_NONE,
		rpin_prev: 1'b1,
		default: '0
	};

	localparam logic [sflf_pkg::SHORT_W-1:0] SHORT_LIMIT = sflf_pkg::SHORT_W'(SHORT_CYCLES);

	sflf_top_state_type      st_q, st_d;
	sflf_pkg::sflf_pins_type raw;
	logic [7:0]              qual_cond;
	logic [7:0]              qual_hit;
	logic [7:0]              set_a, still_a, set_b, still_b;
	logic [7:0]              lin1_n, lin2_n;
	logic                    short_evt;
	logic                    clr_lin1, clr_lin2, clr_a, clr_b;

	sflf_frame_if frame ();

	// ==========================================================
	// Pin gathering; one struct so every pin gets the same two stages
	assign raw = '{
		sclk: sclk, cs_n: cs_n, mosi: mosi,
		lin1_cond: lin1_cond, lin2_cond: lin2_cond,
		lin1_state: lin1_state, lin1_wake_en: lin1_wake_en,
		lin2_state: lin2_state, lin2_wake_en: lin2_wake_en,
		aux_low: aux_low, aux_oc: aux_oc, bus_thermal: bus_thermal, bus_uv: bus_uv,
		bus_oc: bus_oc, sense_low: sense_low, batt_uv: batt_uv,
		main_oc: main_oc, normal_mode: normal_mode, lp_oc: lp_oc, lp_vdd_on: lp_vdd_on,
		main_thermal_off: main_thermal_off, batt_fail: batt_fail,
		reset_pin_n: reset_pin_n
	};

	// ==========================================================
	// Persistence filters for the timed supply faults
	assign qual_cond[0] = st_q.s2.aux_low;
	assign qual_cond[1] = st_q.s2.aux_oc;
	assign qual_cond[2] = st_q.s2.bus_uv;
	assign qual_cond[3] = st_q.s2.bus_oc;
	assign qual_cond[4] = st_q.s2.sense_low;
	assign qual_cond[5] = st_q.s2.batt_uv;
	// Mode gating sits before the filter, so a mode change restarts the count
	assign qual_cond[6] = st_q.s2.main_oc && st_q.s2.normal_mode;
	assign qual_cond[7] = st_q.s2.lp_oc && st_q.s2.lp_vdd_on;

	for (genvar i = 0; i < 8; i++) begin : g_qual
		sflf_qual u_qual (
			.core_clk (core_clk),
			.rst      (rst),
			.cond     (qual_cond[i]),
			.hit      (qual_hit[i])
		);
	end

	// ==========================================================
	// Serial frame engine
	assign frame.sclk = st_q.s2.sclk;
	assign frame.cs_n = st_q.s2.cs_n;
	assign frame.mosi = st_q.s2.mosi;

	sflf_spi u_spi (
		.core_clk (core_clk),
		.rst      (rst),
		.f        (frame)
	);

	// Answer byte, picked as soon as bit 7 of the frame is in
	always_comb begin
		unique case (sflf_pkg::grp_of(frame.cmd))
			sflf_pkg::GRP_LIN1_FLAG: frame.resp = {1'b0, st_q.lin1};
			sflf_pkg::GRP_LIN2_FLAG: frame.resp = {1'b0, st_q.lin2};
			sflf_pkg::GRP_LIN1_LIVE: frame.resp = {st_q.s2.lin1_state, st_q.s2.lin1_wake_en, 6'h00};
			sflf_pkg::GRP_LIN2_LIVE: frame.resp = {st_q.s2.lin2_state, st_q.s2.lin2_wake_en, 6'h00};
			sflf_pkg::GRP_REG_A:     frame.resp = st_q.rega;
			sflf_pkg::GRP_REG_B:     frame.resp = st_q.regb;
			sflf_pkg::GRP_NONE:      frame.resp = 8'h00;
			default:                 frame.resp = 8'h00;
		endcase
	end

	assign miso    = frame.miso;
	assign miso_oe = frame.miso_oe;

	// ==========================================================
	// Flag bytes and read clear
	always_comb begin
		st_d = st_q;
		st_d.s1 = raw;
		st_d.s2 = st_q.s1;

		// Remember which flag group the current frame returned
		if (frame.cmd_valid) begin
			st_d.rd_grp = sflf_pkg::grp_of(frame.cmd);
		end
		// Live groups never map to a clear, so a status read leaves flags alone
		clr_lin1 = frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_LIN1_FLAG;
		clr_lin2 = frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_LIN2_FLAG;
		clr_a = frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_REG_A;
		clr_b = frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_REG_B;
		if (frame.frame_done) begin
			st_d.rd_grp = sflf_pkg::GRP_NONE;
		end

		// Transceiver detectors are levels; present level sets and holds
		lin1_n = sflf_pkg::next_flags({1'b0, st_q.lin1}, {1'b0, st_q.s2.lin1_cond},
			{1'b0, st_q.s2.lin1_cond}, clr_lin1);
		lin2_n = sflf_pkg::next_flags({1'b0, st_q.lin2}, {1'b0, st_q.s2.lin2_cond},
			{1'b0, st_q.s2.lin2_cond}, clr_lin2);
		st_d.lin1 = lin1_n[6:0];
		st_d.lin2 = lin2_n[6:0];

		// First supply byte: timed faults set from the filter, hold on the synchronised s2 level
		set_a = 8'h00;
		still_a = 8'h00;
		set_a[sflf_pkg::AUX_LOW] = qual_hit[0];
		set_a[sflf_pkg::AUX_OC] = qual_hit[1];
		set_a[sflf_pkg::BUS_TH] = st_q.s2.bus_thermal;
		set_a[sflf_pkg::BUS_UV] = qual_hit[2];
		set_a[sflf_pkg::BUS_OC] = qual_hit[3];
		set_a[sflf_pkg::SENSE_LO] = qual_hit[4];
		set_a[sflf_pkg::BATT_UV] = qual_hit[5];
		set_a[sflf_pkg::MAIN_OC] = qual_hit[6];
		still_a[sflf_pkg::AUX_LOW] = st_q.s2.aux_low;
		still_a[sflf_pkg::AUX_OC] = st_q.s2.aux_oc;
		still_a[sflf_pkg::BUS_TH] = st_q.s2.bus_thermal;
		still_a[sflf_pkg::BUS_UV] = st_q.s2.bus_uv;
		still_a[sflf_pkg::BUS_OC] = st_q.s2.bus_oc;
		still_a[sflf_pkg::SENSE_LO] = st_q.s2.sense_low;
		still_a[sflf_pkg::BATT_UV] = st_q.s2.batt_uv;
		still_a[sflf_pkg::MAIN_OC] = st_q.s2.main_oc;
		st_d.rega = sflf_pkg::next_flags(st_q.rega, set_a, still_a, clr_a);

		// Reset pin low time, saturating so a long low never wraps into a short one
		if (!st_q.s2.reset_pin_n) begin
			if (st_q.rcnt != SHORT_LIMIT) begin
				st_d.rcnt = st_q.rcnt + 1'b1;
			end
		end else begin
			st_d.rcnt = '0;
		end
		st_d.rpin_prev = st_q.s2.reset_pin_n;
		short_evt = st_q.s2.reset_pin_n && !st_q.rpin_prev && st_q.rcnt < SHORT_LIMIT;

		// Second supply byte
		set_b = 8'h00;
		still_b = 8'h00;
		set_b[sflf_pkg::MAIN_TH] = st_q.s2.main_thermal_off;
		set_b[sflf_pkg::SHORT_RP] = short_evt;
		set_b[sflf_pkg::BATT_FL] = st_q.s2.batt_fail;
		set_b[sflf_pkg::LP_OC] = qual_hit[7];
		still_b[sflf_pkg::MAIN_TH] = st_q.s2.main_thermal_off;
		still_b[sflf_pkg::SHORT_RP] = !st_q.s2.reset_pin_n;
		still_b[sflf_pkg::BATT_FL] = st_q.s2.batt_fail;
		still_b[sflf_pkg::LP_OC] = st_q.s2.lp_oc;
		st_d.regb = sflf_pkg::next_flags(st_q.regb, set_b, still_b, clr_b);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Checks
	sequence pulse_end_short;
		!st_q.s2.reset_pin_n ##1 (st_q.s2.reset_pin_n && st_q.rcnt < SHORT_LIMIT);
	endsequence

	sequence lin1_read_end;
		frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_LIN1_FLAG;
	endsequence

	sequence supply_a_read_end;
		frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_REG_A;
	endsequence

	a_lin1_clear_hold: assert property (
		@(posedge core_clk) disable iff (rst) lin1_read_end |=> st_q.lin1 == $past(st_q.s2.lin1_cond))
		else $error("first LIN flags wrong after read clear");
	a_status_no_clear: assert property (
		@(posedge core_clk) disable iff (rst)
		(frame.frame_done && st_q.rd_grp == sflf_pkg::GRP_LIN2_LIVE)
		|=> st_q.lin2 == ($past(st_q.lin2) | $past(st_q.s2.lin2_cond)))
		else $error("status read disturbed second LIN flags");
	a_lin1_live_byte: assert property (
		@(posedge core_clk) disable iff (rst)
		(frame.cmd_valid && sflf_pkg::grp_of(frame.cmd) == sflf_pkg::GRP_LIN1_LIVE)
		|-> frame.resp == {st_q.s2.lin1_state, st_q.s2.lin1_wake_en, 6'h00})
		else $error("first LIN live byte wrong");
	a_lin2_flag_byte: assert property (
		@(posedge core_clk) disable iff (rst)
		(frame.cmd_valid && sflf_pkg::grp_of(frame.cmd) == sflf_pkg::GRP_LIN2_FLAG)
		|-> frame.resp == {1'b0, st_q.lin2})
		else $error("second LIN flag byte wrong");
	a_bus_thermal_set: assert property (
		@(posedge core_clk) disable iff (rst) st_q.s2.bus_thermal |=> st_q.rega[sflf_pkg::BUS_TH])
		else $error("bus supply thermal flag missed");
	a_batt_fail_set: assert property (
		@(posedge core_clk) disable iff (rst) st_q.s2.batt_fail |=> st_q.regb[sflf_pkg::BATT_FL])
		else $error("battery fail flag missed");
	a_short_pulse: assert property (
		@(posedge core_clk) disable iff (rst) pulse_end_short |=> st_q.regb[sflf_pkg::SHORT_RP])
		else $error("short reset pulse not flagged");
	a_run_oc_gate: assert property (
		@(posedge core_clk) disable iff (rst)
		(!st_q.rega[sflf_pkg::MAIN_OC] && !st_q.s2.normal_mode && !$past(st_q.s2.normal_mode))
		|=> !st_q.rega[sflf_pkg::MAIN_OC])
		else $error("run overcurrent flag set outside normal mode");
	a_main_thermal_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		(st_q.regb[sflf_pkg::MAIN_TH] && st_q.s2.main_thermal_off) |=> st_q.regb[sflf_pkg::MAIN_TH])
		else $error("thermal-off flag dropped while regulator still off");
	// Gating checks look back a cycle, since a hit already in flight may still land
	a_supply_a_clear: assert property (
		@(posedge core_clk) disable iff (rst)
		supply_a_read_end |=> (st_q.rega & ~$past(set_a) & ~$past(still_a)) == 8'h00)
		else $error("first supply flags survived a read with no cause");
	a_lp_oc_gate: assert property (
		@(posedge core_clk) disable iff (rst)
		(!st_q.regb[sflf_pkg::LP_OC] && !st_q.s2.lp_vdd_on && !$past(st_q.s2.lp_vdd_on))
		|=> !st_q.regb[sflf_pkg::LP_OC])
		else $error("low-power overcurrent flag set with regulator off");
	a_long_pulse_ignored: assert property (
		@(posedge core_clk) disable iff (rst)
		(st_q.s2.reset_pin_n && !st_q.rpin_prev && st_q.rcnt == SHORT_LIMIT
			&& !st_q.regb[sflf_pkg::SHORT_RP]) |=> !st_q.regb[sflf_pkg::SHORT_RP])
		else $error("long reset pulse flagged as short");
	a_oe_follows_select: assert property (
		@(posedge core_clk) disable iff (rst) miso_oe != $past(frame.cs_n))
		else $error("serial output enable does not follow select");

endmodule // sflf_top

`default_nettype wire

// ==== verification/sflf_host.sv ====
// Host model: serial master sending 16-bit command frames and capturing the answer byte.
// Assumes a 20 MHz core_clk; every pin change lands just after its rising edge.
`timescale 1ns/1ns
`default_nettype none

module sflf_host (
	input  wire logic core_clk,
	input  wire logic miso,
	output var logic  sclk,
	output var logic  cs_n,
	output var logic  mosi
);
	// ==========================================================
	// Idle pins
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// Frame driver
	// Six-clock phases leave margin over the four-clock minimum; fewer rises abort
	task automatic xfer(input logic [15:0] cmd, input int rises, output logic [7:0] rsp);
		rsp = 8'h00;
		cs_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		for (int i = 0; i < rises; i++) begin
			mosi <= cmd[15 - i];
			repeat (6) @(posedge core_clk);
			sclk <= 1'b1;
			repeat (6) @(posedge core_clk);
			sclk <= 1'b0;
			if (i > 7) rsp[15 - i] = miso; // Answer taken on the fall
		end
		repeat (6) @(posedge core_clk);
		cs_n <= 1'b1;
		mosi <= ~mosi; // Released line never keeps a stale level
		repeat (10) @(posedge core_clk);
	endtask
endmodule // sflf_host

`default_nettype wire

// ==== verification/sflf_top_bench.sv ====
// Self-checking bench for the fault and status flag bank.
// Assumes the host model drives the serial pins; the bench drives every condition level.
`timescale 1ns/1ns
`default_nettype none

module sflf_top_bench;
	logic       core_clk, rst, sclk, cs_n, mosi, miso, miso_oe;
	logic [6:0] lin1_cond, lin2_cond;
	logic       lin1_state, lin1_wake_en, lin2_state, lin2_wake_en;
	logic       aux_low, aux_oc, bus_thermal, bus_uv, bus_oc, sense_low, batt_uv;
	logic       main_oc, normal_mode, lp_oc, lp_vdd_on, main_thermal_off, batt_fail;
	logic       reset_pin_n;
	int         num_errors;
	int         n_compared;

	// ==========================================================
	// Design and host
	// Short pulse limit cut to 50 clocks so the long case stays brief
	sflf_top #(.SHORT_CYCLES(50)) dut_u (
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .lin1_cond(lin1_cond), .lin2_cond(lin2_cond),
		.lin1_state(lin1_state), .lin1_wake_en(lin1_wake_en), .lin2_state(lin2_state),
		.lin2_wake_en(lin2_wake_en), .aux_low(aux_low), .aux_oc(aux_oc),
		.bus_thermal(bus_thermal), .bus_uv(bus_uv), .bus_oc(bus_oc), .sense_low(sense_low),
		.batt_uv(batt_uv), .main_oc(main_oc), .normal_mode(normal_mode), .lp_oc(lp_oc),
		.lp_vdd_on(lp_vdd_on), .main_thermal_off(main_thermal_off), .batt_fail(batt_fail),
		.reset_pin_n(reset_pin_n)
	);

	sflf_host host_u (.core_clk(core_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

	// ==========================================================
	// Clock
	initial core_clk = 1'b0;
	always #25 core_clk = ~core_clk;

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input string what, input logic [15:0] cmd, input logic [7:0] exp);
		logic [7:0] r;
		host_u.xfer(cmd, 16, r);
		check(what, r, exp);
	endtask

	task automatic set_timed(input logic v);
		aux_low <= v;
		aux_oc <= v;
		bus_uv <= v;
		bus_oc <= v;
		sense_low <= v;
		batt_uv <= v;
		main_oc <= v;
		lp_oc <= v;
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// Each bit walked alone; second read proves a present condition survived the first
	task automatic t_lin();
		logic [6:0] a;
		logic [6:0] b;
		for (int k = 0; k < 7; k++) begin
			a = 7'h01 << k;
			b = 7'h40 >> k;
			lin1_cond <= a;
			lin2_cond <= b;
			repeat (8) @(posedge core_clk);
			rd("lin1 flags", 16'he700, {1'b0, a});
			rd("lin2 flags", 16'he900, {1'b0, b});
			lin1_cond <= 7'h00;
			lin2_cond <= 7'h00;
			rd("lin1 kept", 16'he700, {1'b0, a});
			rd("lin2 kept", 16'he900, {1'b0, b});
			rd("lin1 cleared", 16'he700, 8'h00);
			rd("lin2 cleared", 16'he900, 8'h00);
		end
	endtask

	// Live bytes read twice per pattern; a latched flag must survive them
	task automatic t_live();
		lin1_cond <= 7'h20;
		repeat (8) @(posedge core_clk);
		lin1_cond <= 7'h00;
		for (int k = 0; k < 4; k++) begin
			lin1_state <= k[0];
			lin1_wake_en <= k[1];
			lin2_state <= k[1];
			lin2_wake_en <= k[0];
			repeat (8) @(posedge core_clk);
			for (int j = 0; j < 2; j++) begin
				rd("lin1 live", 16'h2780, {k[0], k[1], 6'h00});
				rd("lin2 live", 16'h2980, {k[1], k[0], 6'h00});
			end
		end
		rd("lin1 after live", 16'he700, 8'h20);
	endtask

	// Just short of and just past the 2000-clock qualification, then mode gating
	task automatic t_timed();
		normal_mode <= 1'b1;
		lp_vdd_on <= 1'b0;
		set_timed(1'b1);
		repeat (1995) @(posedge core_clk);
		set_timed(1'b0);
		repeat (8) @(posedge core_clk);
		rd("supply a early", 16'hdf00, 8'h00);
		set_timed(1'b1);
		repeat (2010) @(posedge core_clk);
		set_timed(1'b0);
		repeat (8) @(posedge core_clk);
		rd("supply a set", 16'hdf00, 8'hdf);
		rd("supply b gated", 16'hdf80, 8'h00);
		rd("supply a cleared", 16'hdf00, 8'h00);
		normal_mode <= 1'b0;
		lp_vdd_on <= 1'b1;
		main_oc <= 1'b1;
		lp_oc <= 1'b1;
		repeat (2010) @(posedge core_clk);
		set_timed(1'b0);
		repeat (8) @(posedge core_clk);
		rd("supply b low power", 16'hdf80, 8'h01);
		rd("supply a not run", 16'hdf00, 8'h00);
	endtask

	// Brief pulses; an aborted frame must not clear
	task automatic t_untimed();
		logic [7:0] r;
		bus_thermal <= 1'b1;
		main_thermal_off <= 1'b1;
		batt_fail <= 1'b1;
		repeat (5) @(posedge core_clk);
		bus_thermal <= 1'b0;
		main_thermal_off <= 1'b0;
		batt_fail <= 1'b0;
		repeat (8) @(posedge core_clk);
		fork
			host_u.xfer(16'hdf80, 10, r);
			begin
				repeat (20) @(posedge core_clk);
				check("miso_oe active", {7'h00, miso_oe}, 8'h01);
			end
		join
		check("miso_oe idle", {7'h00, miso_oe}, 8'h00);
		rd("unknown cmd", 16'he100, 8'h00);
		rd("supply b kept", 16'hdf80, 8'h12);
		rd("supply b cleared", 16'hdf80, 8'h00);
		rd("bus thermal", 16'hdf00, 8'h20);
		rd("bus thermal cleared", 16'hdf00, 8'h00);
	endtask

	task automatic t_short();
		reset_pin_n <= 1'b0;
		repeat (20) @(posedge core_clk);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd("short pulse", 16'hdf80, 8'h04);
		rd("short pulse cleared", 16'hdf80, 8'h00);
		reset_pin_n <= 1'b0;
		repeat (80) @(posedge core_clk);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd("long pulse", 16'hdf80, 8'h00);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		num_errors = 0;
		n_compared = 0;
		rst = 1'b1;
		{lin1_cond, lin2_cond, lin1_state, lin1_wake_en, lin2_state, lin2_wake_en} = '0;
		{aux_low, aux_oc, bus_thermal, bus_uv, bus_oc, sense_low, batt_uv} = '0;
		{main_oc, normal_mode, lp_oc, lp_vdd_on, main_thermal_off, batt_fail} = '0;
		reset_pin_n = 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		t_lin();
		t_live();
		t_timed();
		t_untimed();
		t_short();
		complete_run();
	end

	// Runs need about 22000 clocks; the limit leaves wide margin
	initial begin
		repeat (60000) @(posedge core_clk);
		num_errors++;
		complete_run();
	end
endmodule // sflf_top_bench

`default_nettype wire
